// *** hw/sacc_top.sv ***
// converter control top: ahb-lite registers, clock select and sar sequencer
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sacc_top
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        comparator_i,
	input  wire logic        rc_clock_i,
	input  wire logic        sleep_i,
	output logic      [7:0]  dac_code_o,
	output logic      [4:0]  source_enable_o,
	output logic             sample_o,
	output logic             converter_active_o,
	output logic             conversion_done_flag_o,
	output logic             wake_o
);
	////////////////////////////////////////////////////////////////////////////////
	// rc clock pin is resynchronised; the comparator is strobed on this clock and read directly,
	// since two more stages would take a whole bit period at the /2 setting and decide on a stale trial
	logic cmp_sync;
	logic rc_sync;
	logic half_tick;

	assign cmp_sync = comparator_i;
	sacc_sync #(.WIDTH(1)) u_sync
	(
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.async_i (rc_clock_i),
		.sync_o  (rc_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite data phase tracking
	logic       wr_r;
	logic       wr_nxt;
	logic       rd_r;
	logic       rd_nxt;
	logic [3:0] addr_r;
	logic [3:0] addr_nxt;
	logic       addr_ok;

	// zero wait states, always okay; only the low word offsets are mapped
	always_comb
	begin
		addr_ok  = (haddr_i[31:4] == 28'h000_0000) && (haddr_i[1:0] == 2'h0) && (hsize_i == 3'h2);
		wr_nxt   = 1'b0;
		rd_nxt   = 1'b0;
		addr_nxt = addr_r;
		if (hsel_i && htrans_i[1] && hready_i)
		begin
			wr_nxt   = hwrite_i && addr_ok;
			rd_nxt   = !hwrite_i && addr_ok;
			addr_nxt = haddr_i[3:0];
		end
		hreadyout_o = 1'b1;
		hresp_o     = 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
			addr_r <= 4'h0;
		end
		else
		begin
			wr_r   <= wr_nxt;
			rd_r   <= rd_nxt;
			addr_r <= addr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control, result and sequencer state
	sacc_pkg::sacc_state_type state_r;
	sacc_pkg::sacc_state_type state_nxt;
	logic [2:0] clk_sel_r;
	logic [2:0] clk_sel_nxt;
	logic [2:0] chs_r;
	logic [2:0] chs_nxt;
	logic       go_r;
	logic       go_nxt;
	logic       on_r;
	logic       on_nxt;
	logic [7:0] result_r;
	logic [7:0] result_nxt;
	logic       flag_r;
	logic       flag_nxt;
	logic       ie_r;
	logic       ie_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [2:0] bitpos_r;
	logic [2:0] bitpos_nxt;
	logic [7:0] work_r;
	logic [7:0] work_nxt;
	logic       last_r;
	logic       last_nxt;
	logic       any_r;
	logic       any_nxt;
	logic [1:0] dly_r;
	logic [1:0] dly_nxt;
	logic [7:0] dac_r;
	logic [7:0] dac_nxt;
	logic       rc_sel;
	logic       powered;
	logic       flag_set;
	logic       flag_clr;
	logic [7:0] partial;
	logic [7:0] decided;
	logic       wr_ctl;

	sacc_tad_gen u_tad
	(
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.run_i       (state_r == sacc_pkg::ST_CONV),
		.clk_sel_i   (clk_sel_r),
		.rc_level_i  (rc_sync),
		.half_tick_o (half_tick)
	);

	// next-state of registers and sequencer
	always_comb
	begin
		state_nxt   = state_r;
		clk_sel_nxt = clk_sel_r;
		chs_nxt     = chs_r;
		go_nxt      = go_r;
		on_nxt      = on_r;
		result_nxt  = result_r;
		ie_nxt      = ie_r;
		cnt_nxt     = cnt_r;
		bitpos_nxt  = bitpos_r;
		work_nxt    = work_r;
		last_nxt    = last_r;
		any_nxt     = any_r;
		dly_nxt     = dly_r;
		flag_set    = 1'b0;
		flag_clr    = 1'b0;
		rc_sel      = (clk_sel_r[1:0] == sacc_pkg::CLK_RC_LOW);
		powered     = on_r && !(sleep_i && !rc_sel);
		wr_ctl      = wr_r && (addr_r == sacc_pkg::OFS_CONTROL);
		decided     = work_r;
		decided[bitpos_r] = cmp_sync;
		// unresolved bits copy the last decided bit
		for (int j = 0; j < 8; j++)
		begin
			if (j > int'(bitpos_r))
				partial[j] = work_r[j];
			else
				partial[j] = any_r && last_r;
		end
		case (state_r)
			sacc_pkg::ST_IDLE:
				dly_nxt = 2'h0;
			sacc_pkg::ST_DELAY:
			begin
				// extra instruction cycle before an rc-clocked start
				if (dly_r == sacc_pkg::INSTR_CYCLES)
				begin
					state_nxt = sacc_pkg::ST_CONV;
					cnt_nxt   = 5'h00;
				end
				else
					dly_nxt = dly_r + 2'h1;
			end
			sacc_pkg::ST_CONV:
			begin
				if (half_tick)
				begin
					cnt_nxt = cnt_r + 5'h01;
					// decisions on even halves after sampling, msb first
					if (cnt_r > sacc_pkg::SAMPLE_HALVES && !cnt_r[0])
					begin
						work_nxt = decided;
						last_nxt = cmp_sync;
						any_nxt  = 1'b1;
						if (cnt_r == sacc_pkg::LAST_HALF)
						begin
							state_nxt  = sacc_pkg::ST_IDLE;
							go_nxt     = 1'b0;
							result_nxt = decided;
							flag_set   = 1'b1;
						end
						else
							bitpos_nxt = bitpos_r - 3'h1;
					end
				end
			end
			default:
				state_nxt = sacc_pkg::ST_IDLE;
		endcase
		// power loss aborts quietly, enable bit is left alone
		if (state_r != sacc_pkg::ST_IDLE && !powered)
		begin
			state_nxt = sacc_pkg::ST_IDLE;
			go_nxt    = 1'b0;
		end
		// control register writes
		if (wr_ctl)
		begin
			clk_sel_nxt = hwdata_i[sacc_pkg::CTL_CLK_LSB +: 3];
			chs_nxt     = hwdata_i[sacc_pkg::CTL_CHS_LSB +: 3];
			on_nxt      = hwdata_i[sacc_pkg::CTL_ON_BIT];
			if (hwdata_i[sacc_pkg::CTL_GO_BIT] && on_r && powered && state_r == sacc_pkg::ST_IDLE)
			begin
				go_nxt     = 1'b1;
				state_nxt  = rc_sel ? sacc_pkg::ST_DELAY : sacc_pkg::ST_CONV;
				cnt_nxt    = 5'h00;
				bitpos_nxt = 3'h7;
				work_nxt   = 8'h00;
				any_nxt    = 1'b0;
				last_nxt   = 1'b0;
				dly_nxt    = 2'h0;
			end
			else if (!hwdata_i[sacc_pkg::CTL_GO_BIT] && state_r != sacc_pkg::ST_IDLE)
			begin
				// software abort keeps the bits found so far, no flag
				state_nxt  = sacc_pkg::ST_IDLE;
				go_nxt     = 1'b0;
				result_nxt = partial;
			end
			if (!hwdata_i[sacc_pkg::CTL_ON_BIT])
			begin
				state_nxt = sacc_pkg::ST_IDLE;
				go_nxt    = 1'b0;
			end
		end
		if (wr_r && addr_r == sacc_pkg::OFS_RESULT)
			result_nxt = hwdata_i[7:0];
		if (wr_r && addr_r == sacc_pkg::OFS_IRQ)
		begin
			ie_nxt   = hwdata_i[sacc_pkg::IRQ_EN_BIT];
			flag_clr = hwdata_i[sacc_pkg::IRQ_FLAG_BIT];
		end
		// set wins over a clear in the same cycle
		flag_nxt = (flag_r && !flag_clr) || flag_set;
		if (state_nxt == sacc_pkg::ST_IDLE)
			dac_nxt = 8'h00;
		else
			dac_nxt = work_nxt | (8'h01 << bitpos_nxt);
	end

	// register stage, reset clears everything except bitpos_r, which loads 7
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state_r   <= sacc_pkg::ST_IDLE;
			clk_sel_r <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_CLK_LSB +: 3];
			chs_r     <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_CHS_LSB +: 3];
			go_r      <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_GO_BIT];
			on_r      <= sacc_pkg::CONTROL_RESET[sacc_pkg::CTL_ON_BIT];
			result_r  <= sacc_pkg::RESULT_RESET;
			flag_r    <= 1'b0;
			ie_r      <= 1'b0;
			cnt_r     <= 5'h00;
			bitpos_r  <= 3'h7;
			work_r    <= 8'h00;
			last_r    <= 1'b0;
			any_r     <= 1'b0;
			dly_r     <= 2'h0;
			dac_r     <= 8'h00;
		end
		else
		begin
			state_r   <= state_nxt;
			clk_sel_r <= clk_sel_nxt;
			chs_r     <= chs_nxt;
			go_r      <= go_nxt;
			on_r      <= on_nxt;
			result_r  <= result_nxt;
			flag_r    <= flag_nxt;
			ie_r      <= ie_nxt;
			cnt_r     <= cnt_nxt;
			bitpos_r  <= bitpos_nxt;
			work_r    <= work_nxt;
			last_r    <= last_nxt;
			any_r     <= any_nxt;
			dly_r     <= dly_nxt;
			dac_r     <= dac_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux and analog-side outputs
	always_comb
	begin
		hrdata_o = 32'h0000_0000;
		if (rd_r)
		begin
			case (addr_r)
				sacc_pkg::OFS_CONTROL: hrdata_o[7:0] = {clk_sel_r, chs_r, go_r, on_r};
				sacc_pkg::OFS_RESULT:  hrdata_o[7:0] = result_r;
				sacc_pkg::OFS_IRQ:     hrdata_o[1:0] = {ie_r, flag_r};
				default:               hrdata_o = 32'h0000_0000;
			endcase
		end
		// one source per code, reserved codes connect nothing
		source_enable_o = 5'h00;
		case (chs_r)
			sacc_pkg::CHS_PIN0: source_enable_o[0] = on_r;
			sacc_pkg::CHS_PIN1: source_enable_o[1] = on_r;
			sacc_pkg::CHS_PIN2: source_enable_o[2] = on_r;
			sacc_pkg::CHS_TEMP: source_enable_o[sacc_pkg::SRC_TEMP] = on_r;
			sacc_pkg::CHS_FVR:  source_enable_o[sacc_pkg::SRC_FVR] = on_r;
			default:            source_enable_o = 5'h00;
		endcase
		dac_code_o             = dac_r;
		sample_o               = (state_r != sacc_pkg::ST_CONV) || (cnt_r < sacc_pkg::SAMPLE_HALVES);
		converter_active_o     = powered;
		conversion_done_flag_o = flag_r;
		wake_o                 = flag_r && ie_r && sleep_i;
	end
endmodule
`default_nettype wire

// *** hw/sacc_pkg.sv ***
// package of constants for the successive-approximation converter control block
// Overview of operation
// - eight-bit result found by successive approximation, stored in the result register
// - channel select field routes one of five sources to the sample-and-hold
// - clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC
// - one full conversion lasts 9.5 bit-conversion periods
// - done flag sets at every conversion end, whatever the irq enable
// - completion with irq enabled wakes the sleeping device
// - writing go=1 while enabled starts a conversion on the selected channel
// - at the end: go clears, done flag sets, result loads
// - software clearing go mid-conversion stores a partial result, unresolved bits copy the last
// - reset returns all registers to reset values and ends any conversion
// - one channel code is the temperature indicator feeding the converter
// - with the RC clock, the start waits one extra instruction cycle
// - sleep with a non-RC clock aborts and powers down, enable stays set
package sacc_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_RESULT  = 4'h4;
	localparam logic [3:0] OFS_IRQ     = 4'h8;
	// control register fields
	localparam int CTL_ON_BIT   = 0;
	localparam int CTL_GO_BIT   = 1;
	localparam int CTL_CHS_LSB  = 2;
	localparam int CTL_CLK_LSB  = 5;
	// irq register fields
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_EN_BIT   = 1;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET  = 8'h00;
	// channel codes
	localparam logic [2:0] CHS_PIN0 = 3'h0;
	localparam logic [2:0] CHS_PIN1 = 3'h1;
	localparam logic [2:0] CHS_PIN2 = 3'h2;
	localparam logic [2:0] CHS_TEMP = 3'h6;
	localparam logic [2:0] CHS_FVR  = 3'h7;
	// source enable positions
	localparam int SRC_TEMP = 3;
	localparam int SRC_FVR  = 4;
	// conversion clock select codes
	localparam logic [2:0] CLK_DIV2  = 3'h0;
	localparam logic [2:0] CLK_DIV4  = 3'h4;
	localparam logic [2:0] CLK_DIV8  = 3'h1;
	localparam logic [2:0] CLK_DIV16 = 3'h5;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h6;
	localparam logic [1:0] CLK_RC_LOW = 2'h3;
	// timing in half bit-periods: 19 halves make 9.5 periods
	localparam logic [4:0] SAMPLE_HALVES = 5'h03;
	localparam logic [4:0] LAST_HALF     = 5'h12;
	// one instruction cycle in system clocks
	localparam logic [1:0] INSTR_CYCLES  = 2'h3;
	localparam int         SYNC_STAGES   = 2;
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} sacc_state_type;
endpackage

// *** hw/sacc_sync.sv ***
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module sacc_sync #(parameter int WIDTH = 1)
(
	input  wire logic             mclk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	// first stage feeds only the second
	always_comb
	begin
		meta_nxt = async_i;
		sync_nxt = meta_r;
	end

	// both stages
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			meta_r <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_o <= sync_nxt;
		end
	end
endmodule
`default_nettype wire

// *** hw/sacc_tad_gen.sv ***
// half bit-period enable pulse generator for the conversion clock
`timescale 1ns/100ps
`default_nettype none
module sacc_tad_gen
(
	input  wire logic       mclk_i,
	input  wire logic       reset_i,
	input  wire logic       run_i,
	input  wire logic [2:0] clk_sel_i,
	input  wire logic       rc_level_i,
	output logic            half_tick_o
);
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic       rc_prev_r;
	logic       rc_prev_nxt;
	logic [5:0] half_len;

	// divider length per select code, RC takes every edge of the synced clock
	always_comb
	begin
		case (clk_sel_i)
			sacc_pkg::CLK_DIV2:  half_len = 6'h01;
			sacc_pkg::CLK_DIV4:  half_len = 6'h02;
			sacc_pkg::CLK_DIV8:  half_len = 6'h04;
			sacc_pkg::CLK_DIV16: half_len = 6'h08;
			sacc_pkg::CLK_DIV32: half_len = 6'h10;
			sacc_pkg::CLK_DIV64: half_len = 6'h20;
			default:             half_len = 6'h01;
		endcase
		rc_prev_nxt = rc_level_i;
		half_tick_o = 1'b0;
		cnt_nxt     = 6'h00;
		if (run_i)
		begin
			if (clk_sel_i[1:0] == sacc_pkg::CLK_RC_LOW)
				half_tick_o = rc_level_i ^ rc_prev_r;
			else if (cnt_r == half_len - 6'h01)
				half_tick_o = 1'b1;
			else
				cnt_nxt = cnt_r + 6'h01;
		end
	end

	// counter and rc edge memory
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			cnt_r     <= 6'h00;
			rc_prev_r <= 1'b0;
		end
		else
		begin
			cnt_r     <= cnt_nxt;
			rc_prev_r <= rc_prev_nxt;
		end
	end
endmodule
`default_nettype wire

// *** verification/sacc_analog_model.sv ***
// behavioural analog sources and sample-and-hold feeding the comparator
`timescale 1ns/100ps
`default_nettype none
module sacc_analog_model
(
	input  wire logic       mclk_i,
	input  wire logic       sample_i,
	input  wire logic [4:0] source_enable_i,
	input  wire logic [7:0] dac_code_i,
	output logic            comparator_o
);
	// pin0, pin1, pin2, temperature indicator, fixed reference, in lsb units
	localparam logic [7:0] LEVEL [5] = '{8'h5A, 8'hC3, 8'h01, 8'h80, 8'hFF};
	logic [7:0] held_r;
	logic [7:0] held_nxt;
	// hold node tracks the selected source while sampling; no source reads 0
	always_comb
	begin
		held_nxt = held_r;
		if (sample_i)
		begin
			held_nxt = 8'h00;
			for (int i = 0; i < 5; i++)
				if (source_enable_i[i])
					held_nxt = LEVEL[i];
		end
	end
	// hold capacitor
	always_ff @(posedge mclk_i)
		held_r <= held_nxt;
	// high while the held level is at or above the trial code
	assign comparator_o = held_r >= dac_code_i;
endmodule
`default_nettype wire

// *** verification/sacc_chk.sv ***
// port-level checker for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sacc_chk
(
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic       hwrite_i,
	input wire logic       hreadyout_o,
	input wire logic       hresp_o,
	input wire logic       sleep_i,
	input wire logic [7:0] dac_code_o,
	input wire logic [4:0] source_enable_o,
	input wire logic       sample_o,
	input wire logic       converter_active_o,
	input wire logic       conversion_done_flag_o,
	input wire logic       wake_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// first trial code after idle, and the step after the msb is decided
	sequence conv_start;
		dac_code_o == 8'h80 && $past(dac_code_o) == 8'h00;
	endsequence
	sequence msb_step;
		$past(dac_code_o) == 8'h80 && dac_code_o != 8'h80 && dac_code_o != 8'h00;
	endsequence
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or not okay");
	src_onehot_a: assert property ($onehot0(source_enable_o))
		else $error("more than one source routed");
	wake_cause_a: assert property (wake_o |-> sleep_i && conversion_done_flag_o)
		else $error("wake without sleep and done flag");
	flag_clear_a: assert property ($fell(conversion_done_flag_o) |-> $past(hwrite_i) || $past(hwrite_i, 2))
		else $error("done flag cleared without a write");
	sample_first_a: assert property (conv_start |-> sample_o [*3])
		else $error("sampling period too short");
	msb_first_a: assert property (msb_step |-> dac_code_o[6] && dac_code_o[5:0] == 6'h00)
		else $error("second trial is not bit six");
	sleep_stop_a: assert property ($fell(converter_active_o) |-> ##[0:2] dac_code_o == 8'h00)
		else $error("conversion runs on after power down");
	done_after_a: assert property ($rose(conversion_done_flag_o) |-> !$past(sample_o))
		else $error("done flag set while sampling");
endmodule
`default_nettype wire

// *** verification/sacc_tb_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sacc_tb_top;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel_i = 1'b0;
	logic        hwrite_i = 1'b0;
	logic        hready_i;
	logic        rc_clock_i = 1'b0;
	logic        sleep_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o, q;
	logic [7:0]  dac_code_o;
	logic [4:0]  source_enable_o;
	logic        comparator_i, hreadyout_o, hresp_o, sample_o, converter_active_o, conversion_done_flag_o, wake_o;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	// clock codes, half periods in system clocks, channels and their levels
	localparam logic [2:0] CS [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
	localparam int         HALF [6] = '{1, 2, 4, 8, 16, 32};
	localparam logic [2:0] CH [6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7, 3'h0};
	localparam logic [7:0] LV [6] = '{8'h5A, 8'hC3, 8'h01, 8'h80, 8'hFF, 8'h5A};
	// settling time before a temperature conversion: 200 us at 10 ns per clock
	localparam int         TEMP_WAIT = 20000;
	// the one slave's ready is the bus ready
	assign hready_i = hreadyout_o;
	// system clock and a free-running rc oscillator unrelated in phase
	always #5 mclk_i = ~mclk_i;
	always #37 rc_clock_i = ~rc_clock_i;
	sacc_top sacc_top_i (.mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .comparator_i, .rc_clock_i, .sleep_i, .dac_code_o,
		.source_enable_o, .sample_o, .converter_active_o, .conversion_done_flag_o, .wake_o);
	sacc_analog_model sacc_analog_model_i (.mclk_i, .sample_i(sample_o), .source_enable_i(source_enable_o),
		.dac_code_i(dac_code_o), .comparator_o(comparator_i));
	// compare one value and count it
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// one word transfer: address phase until ready, then data phase until ready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= 2'h2;
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask
	// enable, start, time the conversion, check flag, wake, result, control
	task automatic conv(input logic [2:0] cs, input logic [2:0] ch, input logic [7:0] lv, input int h, input logic sl);
		int n;
		n = 0;
		bus(1'b1, 32'h0, {24'h0, cs, ch, 2'b01});
		if (ch == 3'h6)
			repeat (TEMP_WAIT) @(posedge mclk_i);
		bus(1'b1, 32'h0, {24'h0, cs, ch, 2'b11});
		sleep_i <= sl;
		while (conversion_done_flag_o !== 1'b1 && n < 4000)
		begin
			@(posedge mclk_i);
			n++;
		end
		if (h > 0)
			chk("cycles in window", 32'h1, 32'(n >= 19 * h - 1 && n <= 19 * h + 4));
		chk("done flag", 32'h1, conversion_done_flag_o);
		chk("wake", sl, wake_o);
		sleep_i <= 1'b0;
		bus(1'b0, 32'h4, 32'h0);
		chk("result", lv, q);
		bus(1'b0, 32'h0, 32'h0);
		chk("control", {24'h0, cs, ch, 2'b01}, q);
		bus(1'b1, 32'h8, 32'h1);
	endtask
	// reset values, unmapped address, result written by software
	task automatic t_reset_vals();
		bus(1'b0, 32'h0, 32'h0);
		chk("control reset", 32'h0, q);
		bus(1'b0, 32'h4, 32'h0);
		chk("result reset", 32'h0, q);
		bus(1'b1, 32'h10, 32'hFF);
		bus(1'b0, 32'h10, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, 32'h4, 32'hA5);
		bus(1'b0, 32'h4, 32'h0);
		chk("result write", 32'hA5, q);
	endtask
	// go in the same write that enables starts nothing
	task automatic t_go_refused();
		bus(1'b1, 32'h0, 32'h3);
		bus(1'b0, 32'h0, 32'h0);
		chk("go refused", 32'h1, q);
		repeat (40) @(posedge mclk_i);
		chk("no flag", 32'h0, conversion_done_flag_o);
	endtask
	// each channel code routes its own source or none
	task automatic t_channels();
		logic [4:0] e;
		for (int c = 0; c < 8; c++)
		begin
			e = c < 3 ? 5'(1 << c) : c == 6 ? 5'h08 : c == 7 ? 5'h10 : 5'h00;
			bus(1'b1, 32'h0, 32'(c << 2 | 1));
			@(negedge mclk_i);
			chk("source enable", 32'(e), 32'(source_enable_o));
		end
	endtask
	// all six divided clocks
	task automatic t_clocks();
		for (int i = 0; i < 6; i++)
			conv(CS[i], CH[i], LV[i], HALF[i], 1'b0);
	endtask
	// clearing go in half eleven keeps four bits and copies the last down
	task automatic t_abort();
		bus(1'b1, 32'h0, 32'hC1);
		bus(1'b1, 32'h0, 32'hC3);
		repeat (360) @(posedge mclk_i);
		bus(1'b1, 32'h0, 32'hC1);
		bus(1'b0, 32'h4, 32'h0);
		chk("partial result", 32'h5F, q);
		chk("no flag on abort", 32'h0, conversion_done_flag_o);
	endtask
	// sleep on a divided clock powers down, enable stays
	task automatic t_sleep_abort();
		bus(1'b1, 32'h0, 32'hC5);
		bus(1'b1, 32'h0, 32'hC7);
		repeat (100) @(posedge mclk_i);
		sleep_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		chk("powered down", 32'h0, converter_active_o);
		repeat (700) @(posedge mclk_i);
		chk("no flag in sleep", 32'h0, conversion_done_flag_o);
		sleep_i <= 1'b0;
		bus(1'b0, 32'h0, 32'h0);
		chk("enable kept", 32'h1, {31'h0, q[0]});
		bus(1'b0, 32'h4, 32'h0);
		chk("result kept", 32'h5F, q);
	endtask
	// rc clock: converts in sleep and wakes; the other rc code awake
	task automatic t_rc();
		bus(1'b1, 32'h8, 32'h2);
		conv(3'h3, 3'h6, 8'h80, 0, 1'b1);
		conv(3'h7, 3'h7, 8'hFF, 0, 1'b0);
	endtask
	// reset in mid-conversion ends it and clears the registers
	task automatic t_mid_reset();
		bus(1'b1, 32'h0, 32'hC1);
		bus(1'b1, 32'h0, 32'hC3);
		repeat (50) @(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(negedge mclk_i);
		chk("dac idle", 32'h0, 32'(dac_code_o));
		bus(1'b0, 32'h0, 32'h0);
		chk("control cleared", 32'h0, q);
		repeat (700) @(posedge mclk_i);
		chk("no late flag", 32'h0, conversion_done_flag_o);
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			summarize();
		end
	end
	// main sequence
	initial
	begin
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_reset_vals();
		t_go_refused();
		t_channels();
		t_clocks();
		t_abort();
		t_sleep_abort();
		t_rc();
		t_mid_reset();
		summarize();
	end
endmodule
bind sacc_top sacc_chk sacc_chk_i (.mclk_i, .reset_i, .hwrite_i, .hreadyout_o, .hresp_o, .sleep_i, .dac_code_o,
	.source_enable_o, .sample_o, .converter_active_o, .conversion_done_flag_o, .wake_o);
`default_nettype wire
